// File: bench/dou_top_props.sv
`timescale 1ns/1ns
module dou_top_props (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic [4:0] avsAddress, // address
	input wire logic avsRead, // read
	input wire logic avsWrite, // write
	input wire logic [31:0] avsReadData, // data
	input wire logic avsWaitRequest, // stall
	input wire logic irq, // interrupt
	input wire logic [2:0] eventOut // events
);
	// ==========
	// bus answer: always one wait state
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_wait_answer: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
		else $error("no answer");
	a_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest) else $error("long ack");
	a_ack_cause: assert property (!avsWaitRequest |-> $past(avsRead || avsWrite))
		else $error("stray ack");
	a_rdata_hold: assert property ($changed(avsReadData) |-> avsRead && !avsWaitRequest)
		else $error("read data moved");
	// ==========
	// events are single pulses caused by an operand write
	a_event_pulse: assert property (|eventOut |=> !eventOut)
		else $error("long event");
	a_event_single: assert property ($onehot0(eventOut))
		else $error("two events");
	a_event_cause: assert property (|eventOut |->
		$past(avsWrite && !avsWaitRequest && avsAddress == dou_pkg::ADDR_INPUT))
		else $error("event without write");
	a_irq_clear: assert property ($fell(irq) |-> $past(avsWrite) || $past(avsWrite, 2))
		else $error("irq fell alone");
endmodule // dou_top_props

// File: bench/dou_top_tb.sv
`timescale 1ns/1ns
module dou_top_tb;
	logic clk, rst, avsRead, avsWrite, avsWaitRequest, irq;
	logic [4:0] avsAddress;
	logic [31:0] avsWriteData, avsReadData, q;
	logic [2:0] eventOut;
	logic [3:0] avsByteEnable;
	int fails, samples_checked;
	dou_top u_dut (.clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
		.avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .irq(irq),
		.eventOut(eventOut));
	// ==========
	// report, compare, bus access
	task automatic complete_run;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR %0t got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask
	// request held until waitrequest seen low; a hang ends the run
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= w;
		avsRead <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avsWaitRequest !== 1'b0 && n < 20);
		if (avsWaitRequest !== 1'b0) begin
			fails++;
			complete_run();
		end
		q = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// ==========
	// one operation: event pulse, status, irq, then status cleared
	task automatic op(input logic [7:0] c, input logic [31:0] lo, x, input logic [2:0] ev);
		bus(1'b1, dou_pkg::ADDR_REF_LOW, lo);
		bus(1'b1, dou_pkg::ADDR_REF_HIGH, lo << 1);
		bus(1'b1, dou_pkg::ADDR_CTRL, 32'(c));
		bus(1'b1, dou_pkg::ADDR_INPUT, x);
		// the pulse stands one cycle: take its sampled value at the next edge
		@(posedge clk);
		chk(32'(eventOut), 32'(ev));
		rd(dou_pkg::ADDR_STATUS, 32'(ev));
		chk(32'(irq), 32'(c[7] && |ev));
		bus(1'b1, dou_pkg::ADDR_STAT_CLR, 32'h7);
		rd(dou_pkg::ADDR_STATUS, 32'h0);
	endtask
	task automatic t_regs;
		rd(dou_pkg::ADDR_CTRL, 32'h0);
		rd(dou_pkg::ADDR_IRQ_MASK, 32'h7);
		bus(1'b1, dou_pkg::ADDR_STATUS, 32'h7);
		rd(dou_pkg::ADDR_STATUS, 32'h0);
		rd(5'h02, 32'h0);
		// upper lanes only: the low byte keeps its old value
		avsByteEnable <= 4'he;
		bus(1'b1, dou_pkg::ADDR_REF_LOW, 32'hffff_ffff);
		avsByteEnable <= 4'hf;
		rd(dou_pkg::ADDR_REF_LOW, 32'hffff_ff00);
	endtask
	// every condition against below, low, between, high, above; both sizes
	task automatic t_compare;
		logic [31:0] lo, x;
		logic [5:0] h;
		for (int s = 0; s < 2; s++) begin
			lo = s ? 32'h1_0000 : 32'h100;
			for (int c = 0; c < 6; c++) begin
				for (int i = 0; i < 5; i++) begin
					x = 32'((lo >> 1) * (i + 1));
					h = {x > lo << 1 || x < lo, x > lo && x < lo << 1, x > lo, x < lo, x == lo, x != lo};
					op({s[0], c[2:0], s[0], 3'h0}, lo, x, {2'h0, h[c]});
				end
			end
		end
	endtask
	// carry and borrow at both widths; stop holds the operation back
	task automatic t_arith;
		op(8'h01, 32'hffff, 32'h1, 3'h2);
		op(8'h01, 32'hfffe, 32'h1, 3'h0);
		rd(dou_pkg::ADDR_INPUT, 32'h0000_ffff);
		op(8'h09, 32'hffff, 32'h1, 3'h0);
		op(8'h89, 32'hffff_ffff, 32'h1, 3'h2);
		op(8'h82, 32'h1, 32'h0, 3'h4);
		op(8'h0a, 32'h1_0000, 32'h1, 3'h4);
		rd(dou_pkg::ADDR_INPUT, 32'hffff_0001);
		op(8'h02, 32'h1_0000, 32'h1, 3'h0);
		bus(1'b1, dou_pkg::ADDR_STOP, 32'h1);
		op(8'h01, 32'hffff, 32'h1, 3'h0);
		bus(1'b1, dou_pkg::ADDR_STOP, 32'h0);
	endtask
	task automatic t_irq;
		bus(1'b1, dou_pkg::ADDR_IRQ_MASK, 32'h0);
		bus(1'b1, dou_pkg::ADDR_REF_LOW, 32'h0);
		// operation code 3 also compares; equality of zero against zero
		bus(1'b1, dou_pkg::ADDR_CTRL, 32'h93);
		bus(1'b1, dou_pkg::ADDR_INPUT, 32'h0);
		rd(dou_pkg::ADDR_STATUS, 32'h1);
		chk(32'(irq), 32'h0);
		bus(1'b1, dou_pkg::ADDR_IRQ_MASK, 32'h1);
		rd(dou_pkg::ADDR_IRQ_MASK, 32'h1);
		chk(32'(irq), 32'h1);
		bus(1'b1, dou_pkg::ADDR_STAT_CLR, 32'h1);
		rd(dou_pkg::ADDR_STATUS, 32'h0);
		chk(32'(irq), 32'h0);
	endtask
	// ==========
	// clock, reset and main sequence
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsAddress = 5'h00;
		avsWriteData = 32'h0;
		avsByteEnable = 4'hf;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_compare();
		t_arith();
		t_irq();
		complete_run();
	end
endmodule // dou_top_tb
bind dou_top dou_top_props u_props (.clk(clk), .rst(rst), .avsAddress(avsAddress),
	.avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData),
	.avsWaitRequest(avsWaitRequest), .irq(irq), .eventOut(eventOut));

// File: src/dou_datapath.sv
`timescale 1ns/1ns
module dou_datapath (
	dou_op_if.dp op // request in, events out
);
	// ======================================================
	// operand helper for compare and arithmetic: low half only in narrow mode
	function automatic logic [31:0] trim(input logic [31:0] v, input logic w);
		trim = w ? v : {16'h0000, v[15:0]};
	endfunction

	logic [31:0] a;
	logic [31:0] r0;
	logic [31:0] r1;
	logic [32:0] sum;
	logic [32:0] diff;
	logic hit;
	always_comb begin
		a = trim(op.operand, op.wide);
		r0 = trim(op.refLow, op.wide);
		r1 = trim(op.refHigh, op.wide);
		sum = {1'b0, a} + {1'b0, r0};
		diff = {1'b0, a} - {1'b0, r0};
		// detection condition decode, unsigned compare
		unique case (op.cond)
			dou_pkg::COND_NE: hit = a != r0;
			dou_pkg::COND_EQ: hit = a == r0;
			dou_pkg::COND_LT: hit = a < r0;
			dou_pkg::COND_GT: hit = a > r0;
			dou_pkg::COND_IN: hit = (r0 < a) && (a < r1);
			dou_pkg::COND_OUT: hit = (a < r0) || (r1 < a);
			default: hit = 1'b0; // prohibited codes never fire
		endcase
	end

	// combinational result; the top registers it
	always_comb begin
		op.events = '0;
		op.result = 32'h0000_0000;
		if (op.start) begin
			unique case (op.opMode)
				dou_pkg::OP_ADD: begin
					op.result = trim(sum[31:0], op.wide);
					op.events[dou_pkg::ST_OVF] = op.wide ? sum[32] : sum[16];
				end
				dou_pkg::OP_SUB: begin
					op.result = trim(diff[31:0], op.wide);
					op.events[dou_pkg::ST_UNF] = diff[32];
				end
				default: op.events[dou_pkg::ST_CMP] = hit;
			endcase
		end
	end
endmodule // dou_datapath

// File: src/dou_op_if.sv
`timescale 1ns/1ns
// operation request and result between top and datapath
interface dou_op_if;
	logic start;
	logic [1:0] opMode;
	logic wide;
	logic [2:0] cond;
	logic [31:0] operand;
	logic [31:0] refLow;
	logic [31:0] refHigh;
	logic [31:0] result;
	logic [2:0] events;
	modport ctrl (output start, opMode, wide, cond, operand, refLow, refHigh,
		input result, events);
	modport dp (input start, opMode, wide, cond, operand, refLow, refHigh,
		output result, events);
endinterface

// File: src/dou_pkg.sv
package dou_pkg;
	// ======================================================
	// register map (word offsets as byte addresses)
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_STAT_CLR = 5'h08;
	localparam logic [4:0] ADDR_INPUT = 5'h0c;
	localparam logic [4:0] ADDR_REF_LOW = 5'h10;
	localparam logic [4:0] ADDR_REF_HIGH = 5'h14;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h18;
	localparam logic [4:0] ADDR_STOP = 5'h1c;
	localparam int ADDR_W = 5;
	// ======================================================
	// control field layout
	localparam int OPMODE_LSB = 0;
	localparam int OPMODE_W = 2;
	localparam int SIZE_BIT = 3;
	localparam int COND_LSB = 4;
	localparam int COND_W = 3;
	localparam int IRQEN_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [31:0] MASK_RESET = 32'h0000_0007;
	// status bits
	localparam int ST_CMP = 0;
	localparam int ST_OVF = 1;
	localparam int ST_UNF = 2;
	localparam int ST_W = 3;
	localparam logic [15:0] LIMIT16 = 16'hffff;
	// ======================================================
	typedef enum logic [1:0] {
		OP_COMPARE = 2'h0,
		OP_ADD = 2'h1,
		OP_SUB = 2'h2
	} dou_op_t;
	typedef enum logic [2:0] {
		COND_NE = 3'h0,
		COND_EQ = 3'h1,
		COND_LT = 3'h2,
		COND_GT = 3'h3,
		COND_IN = 3'h4,
		COND_OUT = 3'h5
	} dou_cond_t;
endpackage

// File: src/dou_top.sv
`timescale 1ns/1ns
// How it works
// - compare 16 or 32 bit operands: match, greater/less, in/out of range
// - add or subtract 16 or 32 bit operands
// - size bit 0 selects 16 bit, 1 selects 32 bit
// - detection condition is control bits 6 to 4
// - codes 000 ne, 001 eq, 010 less, 011 greater against low reference
// - code 100 detects low < input < high, bounds exclusive
// - code 101 detects input below low or above high
// - satisfied comparison raises interrupt request when enabled
// - addition overflow past ffff or ffff_ffff is flagged
// - subtraction below zero is flagged as underflow
// - event output pulses for compare, overflow and underflow
// - operand input register is 32 bits wide
// - two reference registers, low bound and high bound
// - flags live in status, cleared through separate clear register
// - module stop halts operation
module dou_top (
	input wire logic clk, // 10 MHz clock
	input wire logic rst, // async reset, high
	input wire logic [4:0] avsAddress, // byte address
	input wire logic avsRead, // read request
	input wire logic avsWrite, // write request
	input wire logic [31:0] avsWriteData, // write data
	input wire logic [3:0] avsByteEnable, // byte lanes
	output logic [31:0] avsReadData, // read data
	output logic avsWaitRequest, // stall
	output logic irq, // level interrupt
	output logic [2:0] eventOut // event link pulses: cmp, ovf, unf
);
	// ======================================================
	// state
	typedef struct packed {
		logic [7:0] ctrl;
		logic [31:0] operand;
		logic [31:0] refLow;
		logic [31:0] refHigh;
		logic [31:0] result;
		logic [2:0] status;
		logic [2:0] mask;
		logic stop;
		logic start;
		logic ack;
		logic stall; // registered waitrequest
		logic [31:0] rdata;
		logic irq;
		logic [2:0] events;
	} dou_state_t;

	dou_state_t s_q;
	dou_state_t s_d;

	dou_op_if op ();

	dou_datapath u_dp (
		.op(op)
	);

	// byte-enable merge used by every writable register
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// ======================================================
	// drive the datapath from registered state
	assign op.start = s_q.start;
	assign op.opMode = s_q.ctrl[dou_pkg::OPMODE_LSB +: dou_pkg::OPMODE_W];
	assign op.wide = s_q.ctrl[dou_pkg::SIZE_BIT];
	assign op.cond = s_q.ctrl[dou_pkg::COND_LSB +: dou_pkg::COND_W];
	assign op.operand = s_q.operand;
	assign op.refLow = s_q.refLow;
	assign op.refHigh = s_q.refHigh;

	logic wr;
	logic rd;
	logic [31:0] wordNow;
	logic [31:0] wordNew;
	logic [2:0] clr;

	// ======================================================
	// next state
	always_comb begin
		s_d = s_q;
		// one wait cycle per access: ack rises the cycle after request
		wr = avsWrite && !s_q.ack;
		rd = avsRead && !s_q.ack;
		s_d.ack = (avsWrite || avsRead) && !s_q.ack;
		s_d.stall = !s_d.ack; // kept in a flop so waitrequest needs no inverter
		s_d.start = 1'b0;
		s_d.events = 3'b000;
		clr = 3'b000;
		unique case (avsAddress)
			dou_pkg::ADDR_CTRL: wordNow = {24'h0, s_q.ctrl};
			dou_pkg::ADDR_STATUS: wordNow = {29'h0, s_q.status};
			dou_pkg::ADDR_INPUT: wordNow = s_q.operand;
			dou_pkg::ADDR_REF_LOW: wordNow = s_q.refLow;
			dou_pkg::ADDR_REF_HIGH: wordNow = s_q.refHigh;
			dou_pkg::ADDR_IRQ_MASK: wordNow = {29'h0, s_q.mask};
			dou_pkg::ADDR_STOP: wordNow = {31'h0, s_q.stop};
			default: wordNow = 32'h0000_0000; // clear reg and unmapped read zero
		endcase
		wordNew = merge(wordNow, avsWriteData, avsByteEnable);
		if (rd) begin
			// result replaces the operand word when read back from input
			s_d.rdata = (avsAddress == dou_pkg::ADDR_INPUT) ? s_q.result : wordNow;
		end
		if (wr) begin
			unique case (avsAddress)
				dou_pkg::ADDR_CTRL: s_d.ctrl = wordNew[7:0];
				dou_pkg::ADDR_STAT_CLR: clr = wordNew[2:0];
				dou_pkg::ADDR_INPUT: begin
					s_d.operand = wordNew;
					s_d.start = !s_q.stop;
				end
				dou_pkg::ADDR_REF_LOW: s_d.refLow = wordNew;
				dou_pkg::ADDR_REF_HIGH: s_d.refHigh = wordNew;
				dou_pkg::ADDR_IRQ_MASK: s_d.mask = wordNew[2:0];
				dou_pkg::ADDR_STOP: s_d.stop = wordNew[0];
				default: ; // status is read-only, unmapped ignored
			endcase
		end
		// operation result: capture and flag, set wins over clear
		if (s_q.start) begin
			s_d.result = op.result;
		end
		s_d.status = (s_q.status & ~clr) | op.events;
		s_d.events = op.events;
		s_d.irq = s_q.ctrl[dou_pkg::IRQEN_BIT] && |(s_d.status & s_d.mask);
	end

	// ======================================================
	// registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.ctrl <= dou_pkg::CTRL_RESET;
			s_q.mask <= dou_pkg::MASK_RESET[2:0];
			s_q.stall <= 1'b1; // idle bus sees a stall
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign avsReadData = s_q.rdata;
	assign avsWaitRequest = s_q.stall;
	assign irq = s_q.irq;
	assign eventOut = s_q.events;
endmodule // dou_top
